// ### logic/vpf_pkg.sv
// Summary of operation
// - each solenoid channel runs either current regulation or open-loop PWM
// - solenoid PWM frequency is software settable between 3.0 kHz and 5.0 kHz
// - regulated mode holds a 10-bit current target per channel
// - PWM mode holds an 8-bit duty cycle per channel
// - pump PWM up to 16 kHz comes from serial command or drive pin
// - pump drain-source overcurrent turns pump gate off and sets its flag
// - overtemperature while pump is on turns gate off and sets its flag
// - pump flags clear by write-one; restart needs clear then drive re-assert
// - solenoid overcurrent while on switches off only that channel and flags it
// - solenoid overcurrent flags clear by write-one; restart needs clear then new setpoint
// - drain state readable on or off, updates only after filter time
// - regulated current outside tolerance raises a regulation error flag
`default_nettype none
package vpf_pkg;
    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ       = 250_000_000;
    localparam int NCH          = 4;
    localparam int PWM_STEPS    = 256;
    localparam int SOL_FMIN_HZ  = 3000;
    localparam int SOL_FMAX_HZ  = 5000;
    localparam int PUMP_FMAX_HZ = 16000;
    localparam int DIV_W        = 9;
    // prescaler counts: the fastest rate rounds up so the limit is never passed
    localparam logic [DIV_W-1:0] SOL_DIV_MIN =
        DIV_W'((CLK_HZ + SOL_FMAX_HZ * PWM_STEPS - 1) / (SOL_FMAX_HZ * PWM_STEPS));
    localparam logic [DIV_W-1:0] SOL_DIV_MAX = DIV_W'(CLK_HZ / (SOL_FMIN_HZ * PWM_STEPS));
    localparam logic [DIV_W-1:0] PUMP_DIV    =
        DIV_W'((CLK_HZ + PUMP_FMAX_HZ * PWM_STEPS - 1) / (PUMP_FMAX_HZ * PWM_STEPS));
    // drain state filter time, rounded up
    localparam int DSF_TIME_NS  = 10000;
    localparam int DSF_W        = 12;
    localparam logic [DSF_W-1:0] DSF_CYC =
        DSF_W'((DSF_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
    // regulation tolerance about 2 percent: target * 5 / 256
    localparam logic [12:0] TOL_NUM   = 13'h0005;
    localparam int          TOL_SHIFT = 8;
    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int AW = 8;
    localparam logic [AW-1:0] OFF_CTRL     = 8'h00;
    localparam logic [AW-1:0] OFF_SOLDIV   = 8'h04;
    localparam logic [AW-1:0] OFF_PUMP     = 8'h08;
    localparam logic [AW-1:0] OFF_SETPT0   = 8'h10;
    localparam logic [AW-1:0] OFF_STATUS   = 8'h20;
    localparam logic [AW-1:0] OFF_CLEAR    = 8'h24;
    localparam logic [AW-1:0] OFF_IRQ_STAT = 8'h28;
    localparam logic [AW-1:0] OFF_IRQ_MASK = 8'h2C;
    // fields
    localparam int CTRL_W        = 6;
    localparam int CTRL_PUMP_SER = 4;
    localparam int CTRL_PUMP_ON  = 5;
    localparam int CLR_SOL       = 0;
    localparam int CLR_PUMP      = 1;
    localparam int SP_W          = 10;
    localparam int DUTY_W        = 8;
    localparam int ST_OC_LSB     = 0;
    localparam int ST_OL_LSB     = 4;
    localparam int ST_DS_LSB     = 8;
    localparam int ST_CRE_LSB    = 12;
    localparam int ST_PUMP_OC    = 16;
    localparam int ST_PUMP_OT    = 17;
    localparam int IRQ_W         = 8;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST  = 6'h00;
    localparam logic [SP_W-1:0]   SETPT_RST = 10'h000;
    localparam logic [DUTY_W-1:0] PUMP_RST  = 8'h00;
    localparam logic [IRQ_W-1:0]  IRQ_RST   = 8'h00;
endpackage : vpf_pkg
`default_nettype wire

// ### logic/vpf_pwm.sv
`timescale 1ns/100ps
`default_nettype none
module vpf_pwm
(
    // clock and reset
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_i,
    // prescaler count and duty
    input  wire logic [vpf_pkg::DIV_W-1:0] div_i,
    input  wire logic [7:0]                duty_i,
    // outputs
    output logic                           pwm_o,
    output logic                           wrap_o
);
    import vpf_pkg::*;

    logic [DIV_W-1:0] pre_r;
    logic [7:0]       cnt_r;
    logic             pwm_r;

    // greater-or-equal so a shrinking divisor never strands the prescaler
    wire [DIV_W-1:0] div_m1 = div_i - DIV_W'(1);
    wire             tick   = (pre_r >= div_m1);
    assign wrap_o = tick && (cnt_r == 8'hFF);
    assign pwm_o  = pwm_r;

    // prescaler and 256-step period counter
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pre_r <= '0;
            cnt_r <= 8'h00;
            pwm_r <= 1'b0;
        end
        else
        begin
            pre_r <= tick ? '0 : pre_r + DIV_W'(1);
            if (tick)
                cnt_r <= cnt_r + 8'h01;
            pwm_r <= (cnt_r < duty_i);
        end
    end

    a_duty_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(cnt_r) >= $past(duty_i) |-> !pwm_o)
        else $error("pwm high past duty");
endmodule // vpf_pwm
`default_nettype wire

// ### logic/vpf_filt.sv
`timescale 1ns/100ps
`default_nettype none
module vpf_filt
(
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // synchronised level in, filtered level out
    input  wire logic in_i,
    output logic      out_o
);
    import vpf_pkg::*;

    logic [DSF_W-1:0] cnt_r;
    logic             out_r;
    assign out_o = out_r;

    // an edge is taken only once the input held its new level for the full time
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_r <= '0;
            out_r <= 1'b0;
        end
        else if (in_i == out_r)
            cnt_r <= '0;
        else if (cnt_r == DSF_CYC - DSF_W'(1))
        begin
            out_r <= in_i;
            cnt_r <= '0;
        end
        else
            cnt_r <= cnt_r + DSF_W'(1);
    end

    a_filt_time: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        out_r != $past(out_r) |-> $past(cnt_r) == DSF_CYC - DSF_W'(1))
        else $error("drain state changed before filter time");
endmodule // vpf_filt
`default_nettype wire

// ### logic/vpf_ctrl.sv
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module vpf_ctrl
(
    // clock and reset
    input  wire logic                                       ref_clk_i,
    input  wire logic                                       rst_i,
    // apb slave
    input  wire logic [vpf_pkg::AW-1:0]                     paddr_i,
    input  wire logic                                       psel_i,
    input  wire logic                                       penable_i,
    input  wire logic                                       pwrite_i,
    input  wire logic [31:0]                                pwdata_i,
    output logic [31:0]                                     prdata_o,
    output logic                                            pready_o,
    output logic                                            pslverr_o,
    output logic                                            irq_o,
    // solenoid channel pins
    input  wire logic [vpf_pkg::NCH-1:0]                    sol_overcurrent_i,
    input  wire logic [vpf_pkg::NCH-1:0]                    sol_open_load_i,
    input  wire logic [vpf_pkg::NCH-1:0]                    sol_drain_i,
    input  wire logic [vpf_pkg::NCH*vpf_pkg::SP_W-1:0]      sol_current_i,
    output logic [vpf_pkg::NCH-1:0]                         sol_gate_o,
    // pump pins
    input  wire logic                                       pump_drive_input_i,
    input  wire logic                                       pump_overcurrent_i,
    input  wire logic                                       pump_overtemp_i,
    output logic                                            pump_gate_output_o
);
    import vpf_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    localparam int SYW = 3 * NCH + 3;
    logic [SYW-1:0] sy1_r;
    logic [SYW-1:0] sy2_r;
    wire  [NCH-1:0] sol_oc_s = sy2_r[NCH-1:0];
    wire  [NCH-1:0] sol_ol_s = sy2_r[2*NCH-1:NCH];
    wire  [NCH-1:0] sol_ds_s = sy2_r[3*NCH-1:2*NCH];
    wire            pdi_s    = sy2_r[3*NCH];
    wire            pump_oc_s = sy2_r[3*NCH+1];
    wire            pump_ot_s = sy2_r[3*NCH+2];

    // two stages on every fault, drain and drive pin (not the current bus); only the second stage is read
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sy1_r <= '0;
            sy2_r <= '0;
        end
        else
        begin
            sy1_r <= {pump_overtemp_i, pump_overcurrent_i, pump_drive_input_i,
                      sol_drain_i, sol_open_load_i, sol_overcurrent_i};
            sy2_r <= sy1_r;
        end
    end

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_r;
    logic [DIV_W-1:0]  sol_div_r;
    logic [DUTY_W-1:0] pump_duty_r;
    logic [SP_W-1:0]   setpt_r [NCH];
    logic [NCH-1:0]    sol_oc_r, sol_ol_r, sol_cre_r, sol_en_r, sol_gate_r;
    logic              pump_oc_r, pump_ot_r, pump_arm_r, pump_gate_r, pdi_d_r;
    logic [IRQ_W-1:0]  irq_stat_r, irq_mask_r;
    logic              irq_r;
    logic [31:0]       prdata_r;
    wire  [NCH-1:0]    sol_ds;

    wire setup_ph  = psel_i && !penable_i;
    wire access_ph = psel_i && penable_i;
    wire wr        = access_ph && pwrite_i;
    wire rd        = access_ph && !pwrite_i;
    wire hit_ctrl  = (paddr_i == OFF_CTRL);
    wire hit_div   = (paddr_i == OFF_SOLDIV);
    wire hit_pump  = (paddr_i == OFF_PUMP);
    wire hit_st    = (paddr_i == OFF_STATUS);
    wire hit_clr   = (paddr_i == OFF_CLEAR);
    wire hit_ist   = (paddr_i == OFF_IRQ_STAT);
    wire hit_imsk  = (paddr_i == OFF_IRQ_MASK);
    wire hit_sp    = (paddr_i[AW-1:4] == OFF_SETPT0[AW-1:4]) && (paddr_i[1:0] == 2'b00);
    wire [1:0] sp_idx = paddr_i[3:2];
    wire mapped    = hit_ctrl | hit_div | hit_pump | hit_st | hit_clr | hit_ist
                   | hit_imsk | hit_sp;
    // zero wait states; unmapped addresses answer with an error
    assign pready_o  = 1'b1;
    assign pslverr_o = access_ph && !mapped;
    assign prdata_o  = prdata_r;

    // status word layout follows the field positions of the map
    wire [31:0] status_w = {14'h0000, pump_ot_r, pump_oc_r, sol_cre_r, sol_ds, sol_ol_r, sol_oc_r};
    wire [31:0] rd_mux =
        hit_ctrl ? {26'h0, ctrl_r} :
        hit_div  ? {23'h0, sol_div_r} :
        hit_pump ? {24'h0, pump_duty_r} :
        hit_sp   ? {22'h0, setpt_r[sp_idx]} :
        hit_st   ? status_w :
        hit_ist  ? {24'h0, irq_stat_r} :
        hit_imsk ? {24'h0, irq_mask_r} : 32'h0000_0000;

    // read data is captured in the setup phase, so clear-on-read drops only
    // the bits that were actually returned, never one that arrived later
    wire st_rd = rd && hit_st;
    wire [NCH-1:0] ol_rd_clr  = st_rd ? prdata_r[ST_OL_LSB +: NCH] : '0;
    wire [NCH-1:0] cre_rd_clr = st_rd ? prdata_r[ST_CRE_LSB +: NCH] : '0;
    wire sol_clr  = wr && hit_clr && pwdata_i[CLR_SOL];
    wire pump_clr = wr && hit_clr && pwdata_i[CLR_PUMP];

    // divisor writes are clamped into the legal frequency band
    wire [15:0] wd = pwdata_i[15:0];
    wire [DIV_W-1:0] div_wval =
        (wd < {7'h00, SOL_DIV_MIN}) ? SOL_DIV_MIN :
        (wd > {7'h00, SOL_DIV_MAX}) ? SOL_DIV_MAX : wd[DIV_W-1:0];

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_r      <= CTRL_RST;
            sol_div_r   <= SOL_DIV_MAX;
            pump_duty_r <= PUMP_RST;
            irq_mask_r  <= IRQ_RST;
            prdata_r    <= 32'h0000_0000;
        end
        else
        begin
            if (wr && hit_ctrl)
                ctrl_r <= pwdata_i[CTRL_W-1:0];
            if (wr && hit_div)
                sol_div_r <= div_wval;
            if (wr && hit_pump)
                pump_duty_r <= pwdata_i[DUTY_W-1:0];
            if (wr && hit_imsk)
                irq_mask_r <= pwdata_i[IRQ_W-1:0];
            if (setup_ph && !pwrite_i)
                prdata_r <= rd_mux;
        end
    end

    // setpoints: 10-bit target, low 8 bits double as duty in pwm mode
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            setpt_r <= '{default: SETPT_RST};
        else if (wr && hit_sp)
            setpt_r[sp_idx] <= pwdata_i[SP_W-1:0];
    end

    // ------------------------------------------------------------------
    // solenoid channels
    // ------------------------------------------------------------------
    logic [NCH-1:0] sp_wr, oc_set, ol_set, cre_set, oc_nxt, en_nxt, gate_nxt;
    logic [NCH-1:0] ol_nxt, cre_nxt;

    generate
        for (genvar i = 0; i < NCH; i++)
        begin : g_ch
            wire            reg_mode = ctrl_r[i];
            wire [SP_W-1:0] target   = setpt_r[i];
            wire [SP_W-1:0] meas     = sol_current_i[i*SP_W +: SP_W];
            wire            pwm, wrap;
            wire [12:0]     prod     = {3'b000, target} * TOL_NUM;
            wire [SP_W-1:0] tol      = SP_W'(prod >> TOL_SHIFT);
            wire [SP_W-1:0] dev      = (meas > target) ? meas - target : target - meas;
            // regulation is hysteretic: on below target, off at or above it
            wire            raw      = reg_mode ? (meas < target) : pwm;

            vpf_pwm u_pwm (
                .ref_clk_i (ref_clk_i),
                .rst_i     (rst_i),
                .div_i     (sol_div_r),
                .duty_i    (target[DUTY_W-1:0]),
                .pwm_o     (pwm),
                .wrap_o    (wrap)
            );

            vpf_filt u_filt (
                .ref_clk_i (ref_clk_i),
                .rst_i     (rst_i),
                .in_i      (sol_ds_s[i]),
                .out_o     (sol_ds[i])
            );

            assign sp_wr[i]  = wr && hit_sp && (sp_idx == 2'(i));
            assign oc_set[i] = sol_oc_s[i] && sol_gate_r[i];
            assign oc_nxt[i] = oc_set[i] || (sol_oc_r[i] && !sol_clr);
            // a new setpoint re-arms only once the flag is already gone
            assign en_nxt[i] = oc_set[i] ? 1'b0 :
                               (sp_wr[i] && !sol_oc_r[i]) ? 1'b1 : sol_en_r[i];
            assign gate_nxt[i] = en_nxt[i] && !oc_nxt[i] && raw;
            assign ol_set[i] = sol_ol_s[i] && !sol_gate_r[i];
            assign ol_nxt[i] = ol_set[i] || (sol_ol_r[i] && !ol_rd_clr[i]);
            // judged once per pwm period so switching ripple is not flagged
            assign cre_set[i] = wrap && reg_mode && sol_en_r[i] && (target != '0)
                              && (dev > tol);
            assign cre_nxt[i] = cre_set[i] || (sol_cre_r[i] && !cre_rd_clr[i]);
        end
    endgenerate

    // flag and gate state for all channels
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sol_oc_r   <= '0;
            sol_ol_r   <= '0;
            sol_cre_r  <= '0;
            sol_en_r   <= '1;
            sol_gate_r <= '0;
        end
        else
        begin
            sol_oc_r   <= oc_nxt;
            sol_ol_r   <= ol_nxt;
            sol_cre_r  <= cre_nxt;
            sol_en_r   <= en_nxt;
            sol_gate_r <= gate_nxt;
        end
    end
    assign sol_gate_o = sol_gate_r;

    // ------------------------------------------------------------------
    // pump pre-driver
    // ------------------------------------------------------------------
    wire pump_pwm;
    wire pdi_rise     = pdi_s && !pdi_d_r;
    wire pump_cmd_wr  = wr && hit_ctrl && pwdata_i[CTRL_PUMP_ON];
    wire pump_rearm   = pdi_rise || pump_cmd_wr;
    wire pump_raw     = ctrl_r[CTRL_PUMP_SER] ? (ctrl_r[CTRL_PUMP_ON] && pump_pwm)
                                              : pdi_s;
    wire pump_oc_set  = pump_oc_s && pump_gate_r;
    wire pump_ot_set  = pump_ot_s && pump_gate_r;
    wire pump_oc_nxt  = pump_oc_set || (pump_oc_r && !pump_clr);
    wire pump_ot_nxt  = pump_ot_set || (pump_ot_r && !pump_clr);
    wire pump_arm_nxt = (pump_oc_set || pump_ot_set) ? 1'b0 :
                        (!pump_oc_r && !pump_ot_r && pump_rearm) ? 1'b1 : pump_arm_r;
    wire pump_gate_nxt = pump_arm_nxt && !pump_oc_nxt && !pump_ot_nxt && pump_raw;

    vpf_pwm u_pump_pwm (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .div_i     (PUMP_DIV),
        .duty_i    (pump_duty_r),
        .pwm_o     (pump_pwm),
        .wrap_o    ()
    );

    // pump fault and gate state
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pump_oc_r   <= 1'b0;
            pump_ot_r   <= 1'b0;
            pump_arm_r  <= 1'b1;
            pump_gate_r <= 1'b0;
            pdi_d_r     <= 1'b0;
        end
        else
        begin
            pump_oc_r   <= pump_oc_nxt;
            pump_ot_r   <= pump_ot_nxt;
            pump_arm_r  <= pump_arm_nxt;
            pump_gate_r <= pump_gate_nxt;
            pdi_d_r     <= pdi_s;
        end
    end
    assign pump_gate_output_o = pump_gate_r;

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------
    wire [IRQ_W-1:0] irq_ev  = {|cre_set, |ol_set, pump_ot_set, pump_oc_set, oc_set};
    wire [IRQ_W-1:0] irq_w1c = (wr && hit_ist) ? pwdata_i[IRQ_W-1:0] : '0;

    // a new event in the clearing cycle stays set
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            irq_stat_r <= IRQ_RST;
            irq_r      <= 1'b0;
        end
        else
        begin
            irq_stat_r <= irq_ev | (irq_stat_r & ~irq_w1c);
            irq_r      <= |(irq_stat_r & irq_mask_r);
        end
    end
    assign irq_o = irq_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_pump_oc_off: assert property (pump_oc_r |-> !pump_gate_r)
        else $error("pump gate on with overcurrent flag");
    a_pump_oc_catch: assert property (pump_gate_r && pump_oc_s |=> pump_oc_r && !pump_gate_r)
        else $error("pump overcurrent not handled");
    a_pump_ot_catch: assert property (pump_gate_r && pump_ot_s |=> pump_ot_r && !pump_gate_r)
        else $error("pump overtemperature not handled");
    a_pump_flag_hold: assert property ((pump_oc_r || pump_ot_r) && !pump_clr
        |=> (pump_oc_r || pump_ot_r))
        else $error("pump flag lost without clear");
    a_pump_rearm: assert property ($rose(pump_arm_r) |-> $past(pump_rearm))
        else $error("pump rearmed without drive request");
    a_sol_oc_off: assert property ((sol_oc_r & sol_gate_r) == '0)
        else $error("solenoid gate on with overcurrent flag");
    a_sol_restart: assert property ((sol_en_r & ~$past(sol_en_r)) != '0 |-> $past(sp_wr) != '0)
        else $error("solenoid rearmed without setpoint write");
    a_open_load: assert property (ol_set != '0 |=> (sol_ol_r & $past(ol_set)) == $past(ol_set))
        else $error("open load flag not set");
    a_div_range: assert property (sol_div_r >= SOL_DIV_MIN && sol_div_r <= SOL_DIV_MAX)
        else $error("solenoid pwm divisor out of band");

    c_pump_oc: cover property (pump_oc_set);
    c_sol_oc: cover property (oc_set != '0);
    c_pump_rearm: cover property ($rose(pump_arm_r));
    c_reg_err: cover property (cre_set != '0);
endmodule // vpf_ctrl
`default_nettype wire

// ### sim/vpf_load.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// coil load: current ramps while gate is on
// ----------------------------------------
module vpf_load
(
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // gates in, measured current out
    input  wire logic [3:0]  gate_i,
    output logic      [39:0] current_o
);
    // a step of 4 keeps ripple narrow; both ends saturate, so no wrap
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            current_o <= 40'h0;
        else
            for (int i = 0; i < 4; i++)
                if (gate_i[i] && current_o[10*i+:10] < 10'h3F0)
                    current_o[10*i+:10] <= current_o[10*i+:10] + 10'h004;
                else if (!gate_i[i] && current_o[10*i+:10] > 10'h003)
                    current_o[10*i+:10] <= current_o[10*i+:10] - 10'h004;
    end
endmodule // vpf_load
`default_nettype wire

// ### sim/valve_pump_fault_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module valve_pump_fault_control_test;
    import vpf_pkg::*;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
    logic [7:0]  padr = 8'h00;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic        prdy, perr, irq, pump_drive_input = 1'b0, p_oc = 1'b0, p_ot = 1'b0, pg;
    logic [3:0]  s_oc = 4'h0, s_ol = 4'h0, s_dr = 4'h0, sg;
    logic [39:0] cur;
    int          n_fail = 0, checks_done = 0;
    vpf_ctrl uut (.ref_clk_i(clk), .rst_i(rst), .paddr_i(padr), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
        .pslverr_o(perr), .irq_o(irq), .sol_overcurrent_i(s_oc), .sol_open_load_i(s_ol),
        .sol_drain_i(s_dr), .sol_current_i(cur), .sol_gate_o(sg), .pump_drive_input_i(pump_drive_input),
        .pump_overcurrent_i(p_oc), .pump_overtemp_i(p_ot), .pump_gate_output_o(pg));
    vpf_load load (.ref_clk_i(clk), .rst_i(rst), .gate_i(sg), .current_o(cur));
    initial forever #2 clk = ~clk;
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // no fixed latency assumed: the access phase holds until pready is seen
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pen, pwr, padr, pwd} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1)
            @(posedge clk);
        rd = prd;
        err = perr;
        {psel, pen} <= 2'b00;
    endtask
    // the trailing delay lets registered outputs settle before sampling
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        apb(1'b0, OFF_SOLDIV, 32'h0);
        chk("div rst", rd, 32'h145);
        apb(1'b1, OFF_SOLDIV, 32'h1FF);
        apb(1'b0, OFF_SOLDIV, 32'h0);
        chk("div high", rd, 32'h145);
        // leave the fastest legal rate so one pwm period fits in the run
        apb(1'b1, OFF_SOLDIV, 32'h0);
        apb(1'b0, OFF_SOLDIV, 32'h0);
        chk("div low", rd, 32'hC4);
        apb(1'b1, OFF_SETPT0, 32'hFFFFFFFF);
        apb(1'b0, OFF_SETPT0, 32'h0);
        chk("setpt", rd, 32'h3FF);
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
    endtask
    task t_sol;
        apb(1'b1, OFF_SETPT0 + 8'h04, 32'hFF);
        tick(5);
        chk("gates on", {28'h0, sg}, 32'h3);
        @(posedge clk);
        s_oc <= 4'h1;
        tick(5);
        chk("ch0 off only", {28'h0, sg}, 32'h2);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("oc flag", {28'h0, rd[3:0]}, 32'h1);
        s_oc <= 4'h0;
        tick(4);
        apb(1'b1, OFF_CLEAR, 32'h1);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("oc cleared", {28'h0, rd[3:0]}, 32'h0);
        tick(5);
        chk("no restart", {31'h0, sg[0]}, 32'h0);
        apb(1'b1, OFF_SETPT0, 32'hFF);
        tick(5);
        chk("restart", {31'h0, sg[0]}, 32'h1);
    endtask
    task t_diag;
        apb(1'b1, OFF_CTRL, 32'h4);
        apb(1'b1, OFF_SETPT0 + 8'h08, 32'h64);
        {s_ol, s_dr} <= 8'h84;
        tick(6);
        @(posedge clk);
        s_ol <= 4'h0;
        tick(200);
        chk("regulate", {31'h0, cur[29:20] >= 10'd88 && cur[29:20] <= 10'd112}, 32'h1);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("open load", {28'h0, rd[7:4]}, 32'h8);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("ol on read", {28'h0, rd[7:4]}, 32'h0);
        chk("drain early", {28'h0, rd[11:8]}, 32'h0);
        tick(2500);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("drain", {28'h0, rd[11:8]}, 32'h4);
    endtask
    task t_pump;
        apb(1'b1, OFF_IRQ_MASK, 32'h30);
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk);
            pump_drive_input <= 1'b1;
            tick(5);
            chk("pump on", {31'h0, pg}, 32'h1);
            @(posedge clk);
            {p_ot, p_oc} <= k ? 2'b10 : 2'b01;
            tick(5);
            chk("pump off", {30'h0, irq, pg}, 32'h2);
            apb(1'b0, OFF_STATUS, 32'h0);
            chk("pump flag", {30'h0, rd[17:16]}, k ? 32'h2 : 32'h1);
            {p_ot, p_oc} <= 2'b00;
            tick(4);
            apb(1'b1, OFF_CLEAR, 32'h2);
            apb(1'b0, OFF_STATUS, 32'h0);
            chk("pump clr", {30'h0, rd[17:16]}, 32'h0);
            apb(1'b1, OFF_IRQ_STAT, 32'h30);
            tick(5);
            chk("held off", {30'h0, irq, pg}, 32'h0);
            @(posedge clk);
            pump_drive_input <= 1'b0;
            tick(5);
            @(posedge clk);
            pump_drive_input <= 1'b1;
            tick(5);
            chk("pump back", {31'h0, pg}, 32'h1);
            @(posedge clk);
            pump_drive_input <= 1'b0;
        end
        apb(1'b1, OFF_PUMP, 32'hFF);
        apb(1'b1, OFF_CTRL, 32'h34);
        tick(5);
        chk("pump serial", {31'h0, pg}, 32'h1);
    endtask
    // the coil never sits at a target of one, so the first period end must flag it
    task t_creg;
        apb(1'b1, OFF_SETPT0 + 8'h08, 32'h1);
        apb(1'b1, OFF_IRQ_MASK, 32'h80);
        while (irq !== 1'b1)
            @(posedge clk);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("reg error", {28'h0, rd[15:12]}, 32'h4);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("reg err on read", {28'h0, rd[15:12]}, 32'h0);
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_sol();
        t_diag();
        t_pump();
        t_creg();
        end_of_test();
    end
    // the run needs about 50k cycles, mostly one pwm period; this allows half again
    initial
    begin
        #300000;
        n_fail++;
        end_of_test();
    end
endmodule // valve_pump_fault_control_test
`default_nettype wire
